/* File: rtl/lux_meter_and_key_protection.sv */
/*
  Register side of the harvesting power manager: key-gated writes,
  soft reset, USB pin control, converter force-off, storage protection
  and the lux-meter register pair.
  Assumes a serial front end that presents one byte access per cycle and
  pulses txn_end when the transaction closes; analog status arrives as
  synchronous levels.
*/
`timescale 1ns/100ps
module lux_meter_and_key_protection #(
  parameter int SETTLE_CYCLES = lux_key_pkg::LUX_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic txn_end,
  input wire logic [7:0] ee_rdata,
  output logic ee_write,
  output logic [5:0] ee_addr,
  output logic [7:0] ee_wdata,
  input wire logic usb_present,
  input wire logic storage_linked,
  input wire logic storage_low_minimum,
  input wire logic boot_done,
  input wire logic lts_below_min,
  input wire logic hrv_low_level,
  input wire logic bat_low_level,
  output logic hrv_low_out,
  output logic hrv_low_oe_n,
  output logic bat_low_out,
  output logic bat_low_oe_n,
  output logic [1:0] usb_charge_sel,
  output logic dcdc_force_off,
  output logic lts_cut,
  output logic lts_protect,
  output logic cold_start,
  output logic soft_reset,
  input wire logic lux_above,
  output logic lux_enable,
  output logic [3:0] lux_level
);
  logic [7:0] unlock_key;
  logic [7:0] soft_reset_trigger;
  logic [7:0] usb_and_wakeup_config;
  logic [7:0] lts_config;
  logic [7:0] power_switch;
  logic [7:0] light_sensor_config;
  logic [7:0] light_sensor_outcome;
  logic wr_prot_ok;
  logic wr_store;
  logic in_store;
  logic soft_fire;
  logic rd_pending;
  logic rd_from_store;
  logic [7:0] rd_hold;
  logic [7:0] store_q;
  lux_ctrl_if lux_bus ();

  assign wr_prot_ok = (reg_addr > lux_key_pkg::ADDR_PROT_LAST)
    || (unlock_key == lux_key_pkg::KEY_REGS);
  assign in_store = (reg_addr < lux_key_pkg::ADDR_EE_FIRST);
  assign wr_store = reg_write && in_store && wr_prot_ok;
  assign soft_fire = (soft_reset_trigger == lux_key_pkg::SOFT_WORD);

  byte_store #(
    .WIDTH(8),
    .DEPTH(64)
  ) u_store (
    .clock(clock),
    .write(wr_store),
    .addr(reg_addr[5:0]),
    .wdata(reg_wdata),
    .rdata(store_q)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      unlock_key <= lux_key_pkg::BYTE_ZERO;
    end else if (txn_end || soft_fire) begin
      unlock_key <= lux_key_pkg::BYTE_ZERO;
    end else if (reg_write && reg_addr == lux_key_pkg::ADDR_UNLOCK) begin
      unlock_key <= reg_wdata;
    end
  end

  // Word held at zero unless keyed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_reset_trigger <= lux_key_pkg::BYTE_ZERO;
    end else if (unlock_key != lux_key_pkg::KEY_SOFT || soft_fire) begin
      soft_reset_trigger <= lux_key_pkg::BYTE_ZERO;
    end else if (reg_write && reg_addr == lux_key_pkg::ADDR_SOFT_RESET) begin
      soft_reset_trigger <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= soft_fire;
    end
  end

  // Shadows of stored configuration that steer logic directly
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      usb_and_wakeup_config <= lux_key_pkg::CFG_RESET;
      lts_config <= lux_key_pkg::CFG_RESET;
    end else if (wr_store && reg_addr == lux_key_pkg::ADDR_USB_CFG) begin
      usb_and_wakeup_config <= reg_wdata;
    end else if (wr_store && reg_addr == lux_key_pkg::ADDR_LTS_CFG) begin
      lts_config <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_switch <= lux_key_pkg::CFG_RESET;
    end else if (reg_write && reg_addr == lux_key_pkg::ADDR_PWR_MGT) begin
      power_switch <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ee_write <= 1'b0;
      ee_addr <= 6'h00;
      ee_wdata <= 8'h00;
    end else begin
      ee_write <= reg_write && !in_store
        && reg_addr < lux_key_pkg::ADDR_EE_RO_FIRST
        && unlock_key == lux_key_pkg::KEY_EE;
      if (reg_write) begin
        ee_addr <= reg_addr[5:0];
        ee_wdata <= reg_wdata;
      end
    end
  end

  assign lux_bus.inhibit = !storage_linked || storage_low_minimum
    || (lts_config[lux_key_pkg::PRIM_CELL_BIT]
    && !lts_config[lux_key_pkg::PRIM_CONNECT_BIT]);
  assign lux_bus.start_once =
    light_sensor_config[lux_key_pkg::LUX_AUTO_MEAS_BIT];
  assign lux_bus.auto_range =
    light_sensor_config[lux_key_pkg::LUX_AUTO_RNG_BIT];
  assign lux_bus.manual = light_sensor_config[lux_key_pkg::LUX_MANU_BIT];
  assign lux_bus.forced_level = light_sensor_config[3:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      light_sensor_config <= lux_key_pkg::CFG_RESET;
    end else if (reg_write && reg_addr == lux_key_pkg::ADDR_LUX_CFG) begin
      // A software write wins over the completion clear
      light_sensor_config <= reg_wdata & lux_key_pkg::LUX_CFG_MASK;
    end else if (lux_bus.done || lux_bus.inhibit) begin
      light_sensor_config[lux_key_pkg::LUX_AUTO_MEAS_BIT] <= 1'b0;
    end
  end

  always_comb begin
    light_sensor_outcome = 8'h00;
    light_sensor_outcome[lux_key_pkg::LUX_BUSY_BIT] = lux_bus.busy;
    light_sensor_outcome[3:0] = lux_bus.result;
  end

  lux_sequencer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_seq (
    .clock(clock),
    .rst(rst),
    .ctrl(lux_bus.seq),
    .lux_above(lux_above),
    .lux_enable(lux_enable),
    .lux_level(lux_level)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_pending <= 1'b0;
      rd_from_store <= 1'b0;
      rd_hold <= 8'h00;
    end else begin
      rd_pending <= reg_read;
      rd_from_store <= 1'b0;
      if (reg_read) begin
        if (reg_addr == lux_key_pkg::ADDR_SOFT_RESET) begin
          rd_hold <= soft_reset_trigger;
        end else if (reg_addr == lux_key_pkg::ADDR_UNLOCK) begin
          rd_hold <= unlock_key;
        end else if (reg_addr == lux_key_pkg::ADDR_LUX_CFG) begin
          rd_hold <= light_sensor_config;
        end else if (reg_addr == lux_key_pkg::ADDR_LUX_OUT) begin
          rd_hold <= light_sensor_outcome;
        end else if (reg_addr == lux_key_pkg::ADDR_PWR_MGT) begin
          rd_hold <= power_switch;
        end else if (!in_store) begin
          rd_hold <= ee_rdata;
        end else begin
          rd_from_store <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (rd_pending) begin
      reg_rdata <= rd_from_store ? store_q : rd_hold;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrv_low_out <= 1'b0;
      bat_low_out <= 1'b0;
      hrv_low_oe_n <= 1'b0;
      bat_low_oe_n <= 1'b0;
    end else begin
      hrv_low_out <= hrv_low_level;
      bat_low_out <= bat_low_level;
      hrv_low_oe_n <= usb_present
        && usb_and_wakeup_config[lux_key_pkg::USB_HRV_HIZ_BIT];
      bat_low_oe_n <= usb_present
        && usb_and_wakeup_config[lux_key_pkg::USB_BAT_HIZ_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      usb_charge_sel <= 2'h0;
      dcdc_force_off <= 1'b0;
    end else begin
      usb_charge_sel <= usb_and_wakeup_config[1:0];
      dcdc_force_off <= power_switch[lux_key_pkg::DCDC_OFF_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lts_protect <= 1'b0;
      cold_start <= 1'b0;
    end else begin
      cold_start <= 1'b0;
      if (boot_done && !lts_protect && lts_below_min
          && !lts_config[lux_key_pkg::NO_PROTECT_BIT]) begin
        lts_protect <= 1'b1;
        cold_start <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lts_cut <= 1'b0;
    end else begin
      lts_cut <= !lts_config[lux_key_pkg::NO_PROTECT_BIT]
        && (lts_below_min || lts_protect);
    end
  end

  property p_soft_fire;
    @(posedge clock) disable iff (rst)
      soft_reset_trigger == lux_key_pkg::SOFT_WORD |=> soft_reset;
  endproperty
  a_soft_fire: assert property (p_soft_fire)
    else $error("soft reset did not fire");

  property p_word_forced;
    @(posedge clock) disable iff (rst)
      unlock_key != lux_key_pkg::KEY_SOFT |=> soft_reset_trigger == 8'h00;
  endproperty
  a_word_forced: assert property (p_word_forced)
    else $error("soft word loaded without key");

  property p_key_after_reset;
    @(posedge clock) disable iff (rst)
      soft_reset |-> unlock_key == 8'h00 && !soft_fire;
  endproperty
  a_key_after_reset: assert property (p_key_after_reset)
    else $error("key survived soft reset");

  property p_protect;
    @(posedge clock) disable iff (rst)
      reg_write && reg_addr == lux_key_pkg::ADDR_USB_CFG
      && unlock_key != lux_key_pkg::KEY_REGS |=> $stable(usb_and_wakeup_config);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected register changed without key");

  property p_txn_clear;
    @(posedge clock) disable iff (rst)
      txn_end |=> unlock_key == 8'h00;
  endproperty
  a_txn_clear: assert property (p_txn_clear)
    else $error("key not cleared at transaction end");

  property p_ee_key;
    @(posedge clock) disable iff (rst)
      ee_write |-> $past(unlock_key) == lux_key_pkg::KEY_EE;
  endproperty
  a_ee_key: assert property (p_ee_key)
    else $error("memory write without key");

  property p_hiz;
    @(posedge clock) disable iff (rst)
      usb_present && usb_and_wakeup_config[lux_key_pkg::USB_HRV_HIZ_BIT]
      |=> hrv_low_oe_n;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("warning pin driven with USB present");

  property p_dcdc;
    @(posedge clock) disable iff (rst)
      reg_write && reg_addr == lux_key_pkg::ADDR_PWR_MGT
      |=> ##1 dcdc_force_off == $past(reg_wdata[7], 2);
  endproperty
  a_dcdc: assert property (p_dcdc)
    else $error("converter force-off does not follow register");

  property p_oneshot;
    @(posedge clock) disable iff (rst)
      lux_bus.done && !(reg_write && reg_addr == lux_key_pkg::ADDR_LUX_CFG)
      |=> !light_sensor_config[lux_key_pkg::LUX_AUTO_MEAS_BIT];
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("one-shot bit not cleared after measurement");

  property p_usb_sel;
    @(posedge clock) disable iff (rst)
      ##1 usb_charge_sel == $past(usb_and_wakeup_config[1:0]);
  endproperty
  a_usb_sel: assert property (p_usb_sel)
    else $error("charge select does not follow register");
endmodule

/* File: rtl/lux_key_pkg.sv */
/*
  Constants of the lux-meter and key-protection block: register offsets,
  field positions, key values, reset values and the settle timing.
  Assumes a 10 MHz core clock and byte-wide serial register access.
*/
package lux_key_pkg;
  localparam logic [6:0] ADDR_LTS_CFG = 7'h06;
  localparam logic [6:0] ADDR_USB_CFG = 7'h13;
  localparam logic [6:0] ADDR_PROT_LAST = 7'h18;
  localparam logic [6:0] ADDR_PWR_MGT = 7'h19;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h1A;
  localparam logic [6:0] ADDR_UNLOCK = 7'h1B;
  localparam logic [6:0] ADDR_LUX_CFG = 7'h1C;
  localparam logic [6:0] ADDR_LUX_OUT = 7'h1D;
  localparam logic [6:0] ADDR_EE_FIRST = 7'h40;
  localparam logic [6:0] ADDR_EE_RO_FIRST = 7'h76;
  localparam logic [7:0] KEY_SOFT = 8'hE2;
  localparam logic [7:0] KEY_REGS = 8'h4B;
  localparam logic [7:0] KEY_EE = 8'hA5;
  localparam logic [7:0] SOFT_WORD = 8'hAB;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] LUX_CFG_MASK = 8'h7F;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int LUX_AUTO_MEAS_BIT = 6;
  localparam int LUX_AUTO_RNG_BIT = 5;
  localparam int LUX_MANU_BIT = 4;
  localparam int LUX_BUSY_BIT = 4;
  localparam int USB_HRV_HIZ_BIT = 3;
  localparam int USB_BAT_HIZ_BIT = 2;
  localparam int DCDC_OFF_BIT = 7;
  localparam int PRIM_CONNECT_BIT = 2;
  localparam int PRIM_CELL_BIT = 1;
  localparam int NO_PROTECT_BIT = 0;
  localparam logic [3:0] LEVEL_FIRST = 4'h1;
  localparam logic [3:0] LEVEL_TOP = 4'hF;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int LUX_SETTLE_US = 50;
  localparam int LUX_SETTLE_CYCLES =
    (CLOCK_HZ / 1_000_000) * LUX_SETTLE_US;
  typedef enum logic [2:0] {
    LUX_IDLE = 3'b001,
    LUX_SEARCH = 3'b010,
    LUX_MANUAL = 3'b100
  } lux_state_e;
endpackage

/* File: rtl/lux_ctrl_if.sv */
/*
  Carrier between the register file and the lux-meter sequencer.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
interface lux_ctrl_if;
  logic start_once;
  logic auto_range;
  logic manual;
  logic inhibit;
  logic [3:0] forced_level;
  logic busy;
  logic done;
  logic [3:0] result;
  modport regs (output start_once, auto_range, manual, inhibit,
    forced_level, input busy, done, result);
  modport seq (input start_once, auto_range, manual, inhibit,
    forced_level, output busy, done, result);
endinterface

/* File: rtl/byte_store.sv */
/*
  Small single-port register store with a registered read.
  Assumes one access per cycle; a write wins over nothing else.
*/
`timescale 1ns/100ps
module byte_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clock,
  input wire logic write,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  // Refused at elaboration: the address port needs at least one bit
  if (WIDTH < 1 || DEPTH < 2) begin : g_bad_size
    $error("byte_store: unsupported size");
  end
  always_ff @(posedge clock) begin
    if (write) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

/* File: rtl/lux_sequencer.sv */
/*
  Lux-meter range search: steps the comparison level upward each settle
  interval until the harvester current falls below the band bound or level 15 is reached.
  Assumes lux_above is high when the current exceeds the lower bound of
  the band selected by lux_level.
*/
`timescale 1ns/100ps
module lux_sequencer #(
  parameter int SETTLE_CYCLES = lux_key_pkg::LUX_SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  lux_ctrl_if.seq ctrl,
  input wire logic lux_above,
  output logic lux_enable,
  output logic [3:0] lux_level
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  lux_key_pkg::lux_state_e state;
  logic [CW-1:0] settle;
  logic tick;
  logic wanted;
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("lux_sequencer: settle count must be at least one");
  end
  assign tick = (settle == CW'(SETTLE_CYCLES - 1));
  assign wanted = ctrl.start_once | ctrl.auto_range;
  assign ctrl.busy = (state == lux_key_pkg::LUX_SEARCH);
  assign lux_enable = (state != lux_key_pkg::LUX_IDLE);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle <= '0;
    end else if (state != lux_key_pkg::LUX_SEARCH || tick) begin
      settle <= '0;
    end else begin
      settle <= settle + CW'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= lux_key_pkg::LUX_IDLE;
      lux_level <= 4'h0;
      ctrl.result <= 4'h0;
      ctrl.done <= 1'b0;
    end else begin
      ctrl.done <= 1'b0;
      case (state)
        lux_key_pkg::LUX_IDLE: begin
          if (ctrl.inhibit) begin
            state <= lux_key_pkg::LUX_IDLE;
          end else if (ctrl.manual) begin
            state <= lux_key_pkg::LUX_MANUAL;
            lux_level <= ctrl.forced_level;
          // Start; done holds off a rerun of a spent one-shot
          end else if (wanted && !ctrl.done) begin
            state <= lux_key_pkg::LUX_SEARCH;
            lux_level <= lux_key_pkg::LEVEL_FIRST;
          end
        end
        lux_key_pkg::LUX_SEARCH: begin
          if (ctrl.inhibit || !wanted || ctrl.manual) begin
            state <= lux_key_pkg::LUX_IDLE;
          end else if (tick) begin
            if (lux_above && lux_level != lux_key_pkg::LEVEL_TOP) begin
              lux_level <= lux_level + 4'h1;
            end else begin
              ctrl.result <= lux_above ? lux_level : lux_level - 4'h1;
              ctrl.done <= 1'b1;
              state <= lux_key_pkg::LUX_IDLE;
            end
          end
        end
        lux_key_pkg::LUX_MANUAL: begin
          lux_level <= ctrl.forced_level;
          if (ctrl.inhibit || !ctrl.manual) begin
            state <= lux_key_pkg::LUX_IDLE;
          end
        end
        default: state <= lux_key_pkg::LUX_IDLE;
      endcase
    end
  end

  property p_busy_enable;
    @(posedge clock) disable iff (rst)
      ctrl.busy |-> lux_enable && lux_level != 4'h0;
  endproperty
  a_busy_enable: assert property (p_busy_enable)
    else $error("busy without an enabled search");

  property p_inhibit_stops;
    @(posedge clock) disable iff (rst)
      ctrl.inhibit |=> !ctrl.busy && !ctrl.done;
  endproperty
  a_inhibit_stops: assert property (p_inhibit_stops)
    else $error("search continued while inhibited");

  property p_no_rerun;
    @(posedge clock) disable iff (rst)
      ctrl.done |=> !ctrl.busy;
  endproperty
  a_no_rerun: assert property (p_no_rerun)
    else $error("search restarted right after completion");
endmodule

/* File: dv/host_model.sv */
/*
  Host side of the register port: byte writes, reads, transaction close.
  Assumes each call may start anywhere; it aligns to a rising edge first.
*/
`timescale 1ns/100ps
module host_model (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  output logic txn_end
);
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    txn_end = 1'b0;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Stale data would hide a late sample
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic close();
    @(posedge clock);
    txn_end <= 1'b1;
    @(posedge clock);
    txn_end <= 1'b0;
  endtask
  task automatic keyed(input logic [7:0] k, input logic [6:0] a,
    input logic [7:0] d);
    wr(7'h1B, k);
    wr(a, d);
    close();
  endtask
endmodule

/* File: dv/lux_meter_and_key_protection_test.sv */
/*
  Self-checking bench of the lux-meter and key-protection block.
  Assumes the host model drives the register port; the meter comparator
  is modelled here from a chosen current band.
*/
`timescale 1ns/100ps
module lux_meter_and_key_protection_test;
  typedef struct {logic [3:0] band; logic [7:0] outcome;} row_s;
  row_s rows[5] = '{'{4'h0, 8'h00}, '{4'h1, 8'h01}, '{4'h7, 8'h07},
    '{4'hE, 8'h0E}, '{4'hF, 8'h0F}};
  logic clock, rst, reg_write, reg_read, txn_end, ee_write;
  logic usb_present, storage_linked, boot_done, lts_below_min;
  logic hrv_low_oe_n, bat_low_oe_n, dcdc_force_off, lts_cut;
  logic lts_protect, cold_start, soft_reset, lux_enable;
  logic hrv_low_out, bat_low_out, storage_low_minimum;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ee_wdata, ee_d, v;
  logic [5:0] ee_addr, ee_a;
  logic [3:0] lux_level, band;
  logic [1:0] usb_charge_sel;
  int n_soft, n_cold, n_ee, check_count, n_mismatch;
  // Comparator: above when the level is not past the band
  wire logic lux_above = (lux_level <= band);
  host_model h (.clock(clock), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .txn_end(txn_end));
  lux_meter_and_key_protection #(.SETTLE_CYCLES(4)) dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .txn_end(txn_end), .ee_rdata(8'h3C),
    .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .usb_present(usb_present), .storage_linked(storage_linked),
    .storage_low_minimum(storage_low_minimum), .boot_done(boot_done),
    .lts_below_min(lts_below_min), .hrv_low_level(1'b1),
    .bat_low_level(1'b1), .hrv_low_out(hrv_low_out),
    .hrv_low_oe_n(hrv_low_oe_n),
    .bat_low_out(bat_low_out), .bat_low_oe_n(bat_low_oe_n),
    .usb_charge_sel(usb_charge_sel), .dcdc_force_off(dcdc_force_off),
    .lts_cut(lts_cut), .lts_protect(lts_protect),
    .cold_start(cold_start), .soft_reset(soft_reset),
    .lux_above(lux_above), .lux_enable(lux_enable),
    .lux_level(lux_level));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Pulses counted on the falling edge, clear of the launch edge
  always @(negedge clock) begin
    if (soft_reset === 1'b1) n_soft++;
    if (cold_start === 1'b1) n_cold++;
    if (ee_write === 1'b1) begin
      n_ee++;
      ee_a = ee_addr;
      ee_d = ee_wdata;
    end
  end
  task automatic chk(input string name, input logic [7:0] e,
    input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic look();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  // Bounded poll until the busy flag drops
  task automatic idle_wait();
    for (int k = 0; k < 40; k++) begin
      h.rd(7'h1D, v);
      if (v[4] === 1'b0) break;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    n_mismatch++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    band = 4'h0;
    usb_present = 1'b1;
    storage_linked = 1'b1;
    storage_low_minimum = 1'b0;
    boot_done = 1'b0;
    lts_below_min = 1'b0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (logic [6:0] a = 7'h1A; a <= 7'h1D; a++) begin
      h.rd(a, v);
      chk("reset value", 8'h00, v);
    end
    foreach (rows[i]) begin
      @(posedge clock);
      band <= rows[i].band;
      h.wr(7'h1C, 8'h40);
      h.rd(7'h1D, v);
      chk("busy", 8'h10, v & 8'h10);
      idle_wait();
      chk("outcome", rows[i].outcome, v);
      h.rd(7'h1C, v);
      chk("start bit", 8'h00, v);
      chk("meter on", 8'h00, {7'h0, lux_enable});
    end
    h.keyed(8'h4B, 7'h13, 8'h0D);
    h.wr(7'h13, 8'h02);
    h.rd(7'h13, v);
    chk("usb config", 8'h0D, v);
    chk("charge select", 8'h01, {6'h0, usb_charge_sel});
    chk("hrv float", 8'h01, {7'h0, hrv_low_oe_n});
    chk("bat float", 8'h01, {7'h0, bat_low_oe_n});
    chk("warning copy", 8'h03, {6'h0, hrv_low_out, bat_low_out});
    @(posedge clock);
    usb_present <= 1'b0;
    look();
    chk("hrv driven", 8'h00, {7'h0, hrv_low_oe_n});
    chk("bat driven", 8'h00, {7'h0, bat_low_oe_n});
    h.wr(7'h1A, 8'hAB);
    h.rd(7'h1A, v);
    chk("word unkeyed", 8'h00, v);
    chk("no restart", 8'h00, 8'(n_soft));
    h.wr(7'h1B, 8'hE2);
    h.wr(7'h1A, 8'hAB);
    h.rd(7'h1B, v);
    chk("key after restart", 8'h00, v);
    chk("restart", 8'h01, 8'(n_soft));
    h.close();
    h.wr(7'h41, 8'h5A);
    look();
    chk("memory unkeyed", 8'h00, 8'(n_ee));
    h.keyed(8'hA5, 7'h41, 8'h5A);
    look();
    chk("memory write", 8'h01, 8'(n_ee));
    chk("memory data", 8'h5A, ee_d);
    chk("memory addr", 8'h01, {2'h0, ee_a});
    h.rd(7'h41, v);
    chk("memory read", 8'h3C, v);
    h.wr(7'h19, 8'h80);
    look();
    chk("converter off", 8'h01, {7'h0, dcdc_force_off});
    h.wr(7'h19, 8'h00);
    look();
    chk("converter auto", 8'h00, {7'h0, dcdc_force_off});
    h.wr(7'h1C, 8'h1A);
    look();
    chk("manual level", 8'h1A, {3'h0, lux_enable, lux_level});
    h.wr(7'h1C, 8'h00);
    look();
    chk("manual off", 8'h00, {7'h0, lux_enable});
    @(posedge clock);
    band <= 4'h5;
    h.wr(7'h1C, 8'h20);
    // Busy drops for only two cycles between searches: wait, then stop
    repeat (80) @(posedge clock);
    h.rd(7'h1C, v);
    chk("range stays", 8'h20, v);
    h.wr(7'h1C, 8'h00);
    h.rd(7'h1D, v);
    chk("range outcome", 8'h05, v);
    @(posedge clock);
    storage_linked <= 1'b0;
    h.wr(7'h1C, 8'h40);
    look();
    chk("refused on", 8'h00, {7'h0, lux_enable});
    h.rd(7'h1D, v);
    chk("result kept", 8'h05, v);
    @(posedge clock);
    storage_linked <= 1'b1;
    storage_low_minimum <= 1'b1;
    h.wr(7'h1C, 8'h40);
    look();
    chk("refused low", 8'h00, {7'h0, lux_enable});
    @(posedge clock);
    storage_low_minimum <= 1'b0;
    band <= 4'h9;
    h.keyed(8'h4B, 7'h06, 8'h02);
    h.wr(7'h1C, 8'h40);
    look();
    chk("refused cell", 8'h00, {7'h0, lux_enable});
    h.keyed(8'h4B, 7'h06, 8'h06);
    h.wr(7'h1C, 8'h40);
    look();
    chk("cell linked on", 8'h01, {7'h0, lux_enable});
    idle_wait();
    chk("cell outcome", 8'h09, v);
    repeat (2) begin
      @(posedge clock);
      lts_below_min <= 1'b1;
      boot_done <= 1'b1;
      @(posedge clock);
      boot_done <= 1'b0;
      look();
    end
    chk("protect", 8'h01, {7'h0, lts_protect});
    chk("cold start once", 8'h01, 8'(n_cold));
    h.keyed(8'h4B, 7'h06, 8'h01);
    look();
    chk("storage kept", 8'h00, {7'h0, lts_cut});
    conclude();
  end
endmodule
